//--- lmx_accu_bank.sv
// four accumulators x, y, z, r with one write port
`timescale 1ns/1ps
`include "lmx_consts.svh"
module lmx_accu_bank import lmx_pkg::*; #(
	parameter int WORD_W = `LMX_WORD_W
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// write port
	input wire logic wr_en,
	input wire logic [1:0] wr_sel,
	input wire logic [WORD_W-1:0] wr_data,
	// register contents
	output logic [3:0][WORD_W-1:0] acc_q
);
	logic [3:0][WORD_W-1:0] acc_r;
	logic [3:0][WORD_W-1:0] acc_nxt;

	// next contents of the selected word
	always_comb begin
		acc_nxt = acc_r;
		if (wr_en) begin
			acc_nxt[wr_sel] = wr_data;
		end
	end

	// registered storage
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acc_r <= '0;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	assign acc_q = acc_r;
endmodule : lmx_accu_bank

//--- lmx_consts.svh
// constants for the logic and miscellaneous instruction unit
`ifndef LMX_CONSTS_SVH
`define LMX_CONSTS_SVH
`define LMX_WORD_W 24
`define LMX_MSB 23
`define LMX_ZERO_WORD 24'h00_0000
`define LMX_BYTES_ACC 3'h2
`define LMX_BYTES_IMM 3'h5
`define LMX_BYTES_NEWCYC 3'h2
`define LMX_BYTES_NOP 3'h1
`define LMX_CYC_ACC 3'h3
`define LMX_CYC_IMM 3'h6
`define LMX_CYC_NEWCYC 3'h3
`define LMX_CYC_NOP 3'h1
`define LMX_CNT_ONE 3'h1
`define LMX_CNT_TWO 3'h2
`define LMX_CNT_ZERO 3'h0
`define LMX_SEL_RESET 2'h0
`define LMX_BYTES_NONE 3'h0
`endif

//--- lmx_logic_exec.sv
// execution unit for nand, nor, or, nop and measurement start
// Contract
// - nand writes not(p1 and p2) into p1, updates sign and zero
// - nor writes not(p1 or p2) into p1, updates sign and zero
// - or writes p1 or p2 into p1, updates sign and zero
// - p1 is an accumulator; p2 an accumulator or 24-bit immediate
// - logic length is 2 bytes with accumulator, 5 with immediate
// - logic takes 3 cycles with accumulator, 6 with immediate
// - newcyc is 2 bytes, 3 cycles, keeps flags, starts a conversion
// - newcyc works any time after reset, from any program
// - nop is 1 byte, 1 cycle, changes nothing
`timescale 1ns/1ps
`include "lmx_consts.svh"
module lmx_logic_exec import lmx_pkg::*; #(
	parameter int WORD_W = `LMX_WORD_W
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// instruction request
	input wire logic instr_valid,
	input wire lmx_op_t instr_op,
	input wire logic [1:0] instr_dst,
	input wire logic [1:0] instr_src,
	input wire logic instr_imm_sel,
	input wire logic [WORD_W-1:0] instr_imm,
	// instruction status
	output logic busy_r,
	output logic done_r,
	output logic [2:0] bytes_r,
	// converter start
	output logic tic_start_r,
	// accumulator preload from other units
	input wire logic acc_ld_en,
	input wire logic [1:0] acc_ld_sel,
	input wire logic [WORD_W-1:0] acc_ld_data,
	// flag preload from other units
	input wire logic flag_ld_en,
	input wire logic [3:0] flag_ld,
	// accumulators and flags
	output logic [3:0][WORD_W-1:0] acc_q,
	output logic sign_r,
	output logic zero_r,
	output logic carry_r,
	output logic ovf_r
);
	lmx_state_t state_r, state_nxt;
	lmx_op_t op_r, op_nxt;
	logic [1:0] dst_r, dst_nxt;
	logic [1:0] src_r, src_nxt;
	logic imm_r, imm_nxt;
	logic [WORD_W-1:0] opa_r, opa_nxt;
	logic [WORD_W-1:0] opb_r, opb_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic busy_nxt, done_nxt, tic_nxt;
	logic [2:0] bytes_nxt;
	logic sign_nxt, zero_nxt, carry_nxt, ovf_nxt;
	logic go;
	logic [2:0] cyc_need;
	logic [WORD_W-1:0] res;
	logic wr_en;
	logic [1:0] wr_sel;
	logic [WORD_W-1:0] wr_data;
	logic is_logic_op;

	assign go = instr_valid && !busy_r;
	assign is_logic_op = (op_r == LMX_OP_NAND) || (op_r == LMX_OP_NOR) || (op_r == LMX_OP_OR);

	// result of the captured logic operation
	always_comb begin
		unique case (op_r)
			LMX_OP_NAND: res = ~(opa_r & opb_r);
			LMX_OP_NOR: res = ~(opa_r | opb_r);
			LMX_OP_OR: res = opa_r | opb_r;
			default: res = opa_r;
		endcase
	end

	// cycle budget of the requested instruction
	always_comb begin
		unique case (instr_op)
			LMX_OP_NOP: cyc_need = `LMX_CYC_NOP;
			LMX_OP_NEWCYC: cyc_need = `LMX_CYC_NEWCYC;
			default: cyc_need = instr_imm_sel ? `LMX_CYC_IMM : `LMX_CYC_ACC;
		endcase
	end

	// sequencer, operand capture and flags
	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		dst_nxt = dst_r;
		src_nxt = src_r;
		imm_nxt = imm_r;
		opa_nxt = opa_r;
		opb_nxt = opb_r;
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		tic_nxt = 1'b0;
		bytes_nxt = bytes_r;
		sign_nxt = sign_r;
		zero_nxt = zero_r;
		carry_nxt = carry_r;
		ovf_nxt = ovf_r;
		wr_en = 1'b0;
		wr_sel = dst_r;
		wr_data = res;
		if (flag_ld_en && !busy_r && !instr_valid) begin
			{carry_nxt, ovf_nxt, sign_nxt, zero_nxt} = flag_ld;
		end
		if (acc_ld_en && !busy_r && !instr_valid) begin
			wr_en = 1'b1;
			wr_sel = acc_ld_sel;
			wr_data = acc_ld_data;
		end
		unique case (state_r)
			LMX_ST_IDLE: begin
				if (go) begin
					op_nxt = instr_op;
					dst_nxt = instr_dst;
					src_nxt = instr_src;
					imm_nxt = instr_imm_sel;
					opa_nxt = acc_q[instr_dst];
					opb_nxt = instr_imm_sel ? instr_imm : acc_q[instr_src];
					if (cyc_need == `LMX_CYC_NOP) begin
						done_nxt = 1'b1;
						bytes_nxt = `LMX_BYTES_NOP;
					end else begin
						state_nxt = LMX_ST_EXEC;
						busy_nxt = 1'b1;
						cnt_nxt = cyc_need - `LMX_CNT_TWO;
					end
				end
			end
			LMX_ST_EXEC: begin
				if (cnt_r == `LMX_CNT_ZERO) begin
					state_nxt = LMX_ST_IDLE;
					busy_nxt = 1'b0;
					done_nxt = 1'b1;
					if (op_r == LMX_OP_NEWCYC) begin
						tic_nxt = 1'b1;
						bytes_nxt = `LMX_BYTES_NEWCYC;
					end else begin
						wr_en = 1'b1;
						wr_sel = dst_r;
						wr_data = res;
						sign_nxt = res[`LMX_MSB];
						zero_nxt = (res == `LMX_ZERO_WORD);
						bytes_nxt = imm_r ? `LMX_BYTES_IMM : `LMX_BYTES_ACC;
					end
				end else begin
					cnt_nxt = cnt_r - `LMX_CNT_ONE;
				end
			end
		endcase
	end

	// state registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_r <= LMX_ST_IDLE;
			op_r <= LMX_OP_NOP;
			dst_r <= `LMX_SEL_RESET;
			src_r <= `LMX_SEL_RESET;
			imm_r <= 1'b0;
			opa_r <= `LMX_ZERO_WORD;
			opb_r <= `LMX_ZERO_WORD;
			cnt_r <= `LMX_CNT_ZERO;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			tic_start_r <= 1'b0;
			bytes_r <= `LMX_BYTES_NONE;
			sign_r <= 1'b0;
			zero_r <= 1'b0;
			carry_r <= 1'b0;
			ovf_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			dst_r <= dst_nxt;
			src_r <= src_nxt;
			imm_r <= imm_nxt;
			opa_r <= opa_nxt;
			opb_r <= opb_nxt;
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			tic_start_r <= tic_nxt;
			bytes_r <= bytes_nxt;
			sign_r <= sign_nxt;
			zero_r <= zero_nxt;
			carry_r <= carry_nxt;
			ovf_r <= ovf_nxt;
		end
	end

	// accumulator storage
	lmx_accu_bank #(
		.WORD_W(WORD_W)
	) u_bank (
		.sys_clk(sys_clk),
		.rst(rst),
		.wr_en(wr_en),
		.wr_sel(wr_sel),
		.wr_data(wr_data),
		.acc_q(acc_q)
	);

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic logic_done;
	assign logic_done = done_r && is_logic_op;

	sequence s_go_acc;
		go && (instr_op inside {LMX_OP_NAND, LMX_OP_NOR, LMX_OP_OR}) && !instr_imm_sel;
	endsequence
	sequence s_go_imm;
		go && (instr_op inside {LMX_OP_NAND, LMX_OP_NOR, LMX_OP_OR}) && instr_imm_sel;
	endsequence
	sequence s_go_newcyc;
		go && instr_op == LMX_OP_NEWCYC;
	endsequence

	property p_nand;
		done_r && op_r == LMX_OP_NAND |-> acc_q[dst_r] == ~(opa_r & opb_r) && sign_r == acc_q[dst_r][`LMX_MSB]
			&& zero_r == (acc_q[dst_r] == `LMX_ZERO_WORD);
	endproperty
	a_nand: assert property (p_nand) else $error("nand result wrong");
	property p_nor;
		done_r && op_r == LMX_OP_NOR |-> acc_q[dst_r] == ~(opa_r | opb_r) && sign_r == acc_q[dst_r][`LMX_MSB]
			&& zero_r == (acc_q[dst_r] == `LMX_ZERO_WORD);
	endproperty
	a_nor: assert property (p_nor) else $error("nor result wrong");
	property p_or;
		done_r && op_r == LMX_OP_OR |-> acc_q[dst_r] == (opa_r | opb_r) && sign_r == acc_q[dst_r][`LMX_MSB]
			&& zero_r == (acc_q[dst_r] == `LMX_ZERO_WORD);
	endproperty
	a_or: assert property (p_or) else $error("or result or flags wrong");
	property p_operand;
		go && instr_imm_sel && instr_op != LMX_OP_NOP |=> opb_r == $past(instr_imm) && opa_r == $past(acc_q[instr_dst]);
	endproperty
	a_operand: assert property (p_operand) else $error("operand capture wrong");
	property p_len;
		logic_done |-> bytes_r == (imm_r ? `LMX_BYTES_IMM : `LMX_BYTES_ACC);
	endproperty
	a_len: assert property (p_len) else $error("instruction length wrong");
	property p_cyc_acc;
		s_go_acc |=> !done_r ##1 !done_r ##1 done_r;
	endproperty
	a_cyc_acc: assert property (p_cyc_acc) else $error("register logic op not 3 cycles");
	property p_cyc_imm;
		s_go_imm |=> (!done_r)[*5] ##1 done_r;
	endproperty
	a_cyc_imm: assert property (p_cyc_imm) else $error("immediate logic op not 6 cycles");
	property p_newcyc;
		s_go_newcyc |=> (!tic_start_r)[*2] ##1 (tic_start_r && done_r && bytes_r == `LMX_BYTES_NEWCYC && $stable(sign_r)
			&& $stable(zero_r) && $stable(carry_r) && $stable(ovf_r));
	endproperty
	a_newcyc: assert property (p_newcyc) else $error("newcyc timing or flags wrong");
	property p_tic_cause;
		tic_start_r |-> done_r && op_r == LMX_OP_NEWCYC;
	endproperty
	a_tic_cause: assert property (p_tic_cause) else $error("converter start without newcyc");
	property p_nop;
		go && instr_op == LMX_OP_NOP |=> done_r && bytes_r == `LMX_BYTES_NOP && !busy_r && $stable(acc_q)
			&& $stable(sign_r) && $stable(zero_r) && $stable(carry_r) && $stable(ovf_r);
	endproperty
	a_nop: assert property (p_nop) else $error("nop changed state");
	property p_keep;
		logic_done |-> $stable(carry_r) && $stable(ovf_r) && (src_r == dst_r || imm_r || $stable(acc_q[src_r]));
	endproperty
	a_keep: assert property (p_keep) else $error("logic op disturbed p2 or carry/overflow");
endmodule : lmx_logic_exec

//--- lmx_pkg.sv
// types for the logic and miscellaneous instruction unit
package lmx_pkg;
	typedef logic [23:0] lmx_word_t;
	typedef logic [3:0][23:0] lmx_bank_t;
	typedef enum logic [2:0] {
		LMX_OP_NOP = 3'b000,
		LMX_OP_NEWCYC = 3'b001,
		LMX_OP_NAND = 3'b010,
		LMX_OP_NOR = 3'b011,
		LMX_OP_OR = 3'b100
	} lmx_op_t;
	typedef enum logic [1:0] {
		LMX_ACC_X = 2'b00,
		LMX_ACC_Y = 2'b01,
		LMX_ACC_Z = 2'b10,
		LMX_ACC_R = 2'b11
	} lmx_acc_t;
	typedef enum logic {
		LMX_ST_IDLE = 1'b0,
		LMX_ST_EXEC = 1'b1
	} lmx_state_t;
endpackage : lmx_pkg

//--- logic_ops_and_misc_instructions_test.sv
// self-checking bench for the logic and miscellaneous instruction unit
`timescale 1ns/1ps
module logic_ops_and_misc_instructions_test import lmx_pkg::*;;
	logic sys_clk, rst, instr_valid, instr_imm_sel, acc_ld_en, flag_ld_en;
	logic busy_r, done_r, tic_start_r, sign_r, zero_r, carry_r, ovf_r;
	lmx_op_t instr_op;
	logic [1:0] instr_dst, instr_src, acc_ld_sel;
	logic [2:0] bytes_r;
	logic [3:0] flag_ld, m_fl;
	lmx_word_t instr_imm, acc_ld_data;
	lmx_bank_t acc_q, m_acc;
	logic [103:0] exp_q[$];
	int tq[$];
	int cyc, n_fail, n_tests, bsy_exp;
	lmx_logic_exec u_dut (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
		.instr_dst(instr_dst), .instr_src(instr_src), .instr_imm_sel(instr_imm_sel), .instr_imm(instr_imm),
		.busy_r(busy_r), .done_r(done_r), .bytes_r(bytes_r), .tic_start_r(tic_start_r), .acc_ld_en(acc_ld_en),
		.acc_ld_sel(acc_ld_sel), .acc_ld_data(acc_ld_data), .flag_ld_en(flag_ld_en), .flag_ld(flag_ld),
		.acc_q(acc_q), .sign_r(sign_r), .zero_r(zero_r), .carry_r(carry_r), .ovf_r(ovf_r));
	// clock generator
	initial begin
		sys_clk = 0;
		forever #4 sys_clk = ~sys_clk;
	end
	task check(input string nm, input logic [103:0] e, input logic [103:0] s);
		n_tests++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, s);
			n_fail++;
		end
	endtask : check
	task final_report;
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report
	// cycle count and hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			final_report;
		end
	end
	// waits for an idle unit at a falling edge
	task wait_idle;
		@(negedge sys_clk);
		check("busy", bsy_exp, busy_r);
		bsy_exp = 0;
		while (busy_r !== 1'b0) @(negedge sys_clk);
	endtask : wait_idle
	// preload one accumulator and optionally the flags
	task preload(input logic [1:0] s, input lmx_word_t d, input logic fe, input logic [3:0] f);
		wait_idle;
		instr_valid = 0;
		acc_ld_en = 1;
		acc_ld_sel = s;
		acc_ld_data = d;
		flag_ld_en = fe;
		flag_ld = f;
		m_acc[s] = d;
		if (fe) m_fl = f;
		@(posedge sys_clk);
	endtask : preload
	// issue one instruction, note result and completion cycle
	task issue(input lmx_op_t op, input logic [1:0] d, input logic [1:0] s, input logic im, input lmx_word_t iv);
		lmx_word_t b;
		lmx_word_t r;
		logic [2:0] nb;
		int n;
		logic tic;
		b = im ? iv : m_acc[s];
		r = m_acc[d];
		tic = 0;
		case (op)
			LMX_OP_NAND: r = ~(r & b);
			LMX_OP_NOR: r = ~(r | b);
			LMX_OP_OR: r = r | b;
			default: ;
		endcase
		if (op == LMX_OP_NOP) begin
			nb = 3'h1;
			n = 1;
		end else if (op == LMX_OP_NEWCYC) begin
			nb = 3'h2;
			n = 3;
			tic = 1;
		end else begin
			nb = im ? 3'h5 : 3'h2;
			n = im ? 6 : 3;
			m_acc[d] = r;
			m_fl[1:0] = {r[23], r == 24'h00_0000};
		end
		wait_idle;
		{acc_ld_en, flag_ld_en} = 2'h0;
		instr_valid = 1'b1;
		instr_op = op;
		{instr_dst, instr_src, instr_imm_sel, instr_imm} = {d, s, im, iv};
		exp_q.push_back({nb, tic, m_fl, m_acc});
		tq.push_back(cyc + n);
		@(posedge sys_clk);
		bsy_exp = (n > 1);
	endtask : issue
	// result monitor
	always @(negedge sys_clk) begin
		if (rst === 1'b0 && done_r === 1'b1) begin
			if (exp_q.size() == 0) check("spurious_done", 0, 1);
			else begin
				check("result", exp_q.pop_front(), {bytes_r, tic_start_r, carry_r, ovf_r, sign_r, zero_r, acc_q});
				check("done_cycle", tq.pop_front(), cyc);
				check("busy_at_done", 0, busy_r);
			end
		end else if (rst === 1'b0) check("tic_idle", 0, tic_start_r);
	end
	// main sequence
	initial begin
		void'($urandom(50478));
		{rst, instr_valid, instr_imm_sel, acc_ld_en, flag_ld_en} = 5'h10;
		instr_op = LMX_OP_NOP;
		{instr_dst, instr_src, acc_ld_sel, flag_ld, instr_imm, acc_ld_data} = '0;
		{m_fl, m_acc} = '0;
		{cyc, n_fail, n_tests, bsy_exp} = 0;
		repeat (10) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 0;
		check("reset_ctl", 0, {busy_r, done_r, bytes_r, tic_start_r, carry_r, ovf_r, sign_r, zero_r});
		check("reset_acc", 0, acc_q);
		issue(LMX_OP_NEWCYC, 2'h0, 2'h0, 1'b0, 24'h00_0000);
		for (int i = 0; i < 4; i++) preload(2'(i), 24'($urandom), 1'b1, 4'($urandom));
		for (int k = 0; k < 24; k++) begin
			if (k % 4 == 0) preload(2'($urandom), 24'($urandom), 1'b1, 4'($urandom));
			issue(lmx_op_t'(3'(2 + k % 3)), 2'($urandom), 2'($urandom), 1'((k / 3) % 2), 24'($urandom));
		end
		// zero and sign corners
		preload(2'h0, 24'hFF_FFFF, 1'b1, 4'hF);
		issue(LMX_OP_NAND, 2'h0, 2'h0, 1'b1, 24'hFF_FFFF);
		issue(LMX_OP_OR, 2'h0, 2'h0, 1'b0, 24'h00_0000);
		issue(LMX_OP_NOR, 2'h0, 2'h0, 1'b0, 24'h00_0000);
		issue(LMX_OP_NEWCYC, 2'h0, 2'h0, 1'b0, 24'h00_0000);
		for (int k = 0; k < 3; k++) issue(LMX_OP_NOP, 2'($urandom), 2'($urandom), 1'b0, 24'h00_0000);
		issue(LMX_OP_NEWCYC, 2'h1, 2'h2, 1'b1, 24'h12_3456);
		wait_idle;
		{instr_valid, acc_ld_en, flag_ld_en} = 3'h0;
		repeat (10) @(negedge sys_clk);
		check("pending", 0, exp_q.size());
		// mid-run reset, then a converter start from a custom sequence
		rst = 1;
		{m_fl, m_acc} = '0;
		repeat (3) @(negedge sys_clk);
		rst = 0;
		check("reset2_ctl", 0, {busy_r, done_r, bytes_r, tic_start_r, carry_r, ovf_r, sign_r, zero_r});
		check("reset2_acc", 0, acc_q);
		issue(LMX_OP_NEWCYC, 2'h3, 2'h0, 1'b0, 24'h00_0000);
		wait_idle;
		instr_valid = 0;
		repeat (4) @(negedge sys_clk);
		check("pending2", 0, exp_q.size());
		final_report;
	end
endmodule : logic_ops_and_misc_instructions_test
